// ---- common/spi_cfg_pkg.sv ----
// Shared constants for the serial port configuration and status block
package spi_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Register byte offsets
  localparam logic [11:0] OFF_CFG_STATUS = 12'h000;
  localparam logic [11:0] OFF_DATA = 12'h004;
  localparam logic [11:0] OFF_INT_STATUS = 12'h008;
  localparam logic [11:0] OFF_INT_MASK = 12'h00c;
  // Config and status field positions
  localparam int BIT_BUSY = 7;
  localparam int BIT_MASTER_EN = 6;
  localparam int BIT_PHASE = 5;
  localparam int BIT_POLARITY = 4;
  localparam int BIT_SLV_SEL = 3;
  localparam int BIT_RAW_SS = 2;
  localparam int BIT_SR_EMPTY = 1;
  localparam int BIT_RX_EMPTY = 0;
  localparam logic [7:0] CFG_STATUS_RST = 8'h07;
  // Interrupt status and mask fields
  localparam int IRQ_W = 2;
  localparam int IRQ_XFER_DONE = 0;
  localparam int IRQ_SEL_EDGE = 1;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  // Data register
  localparam logic [7:0] TX_IDLE_BYTE = 8'hff;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SS_FILTER_NS = 40;
  localparam int SS_FILTER_CYCLES = (SS_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- common/ss_filter_if.sv ----
// Carries raw and de-glitched slave select levels
`timescale 1ns/1ns
`default_nettype none
interface ss_filter_if;
  logic raw_level;
  logic filtered_level;
  modport source (output raw_level, output filtered_level);
  modport sink (input raw_level, input filtered_level);
endinterface
`default_nettype wire

// ---- dv/spi_master_model.sv ----
// External serial master driving the port's slave side
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
  output logic sck_out, // Serial clock to port
  output logic mosi_out, // Serial data to port
  output logic ss_b_out, // Slave select, active low
  input wire logic miso_in // Serial data from port
);
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    ss_b_out = 1'b1;
  end
  // One byte, MSB first; clock stands at its idle level outside the frame
  task automatic xfer(input logic pol, input logic pha, input logic [7:0] tx, output logic [7:0] rx);
    sck_out = pol;
    #80;
    ss_b_out = 1'b0;
    if (!pha) mosi_out = tx[7];
    #200;
    for (int i = 7; i >= 0; i--) begin
      if (pha) mosi_out = tx[i];
      sck_out = ~pol;
      if (!pha) rx[i] = miso_in;
      #80;
      sck_out = pol;
      if (pha) rx[i] = miso_in;
      else if (i > 0) mosi_out = tx[i-1];
      #80;
    end
    ss_b_out = 1'b1;
    mosi_out = ~mosi_out;
    #200;
  endtask
  task automatic select(input logic lvl);
    ss_b_out = lvl;
    if (lvl) mosi_out = ~mosi_out;
  endtask
  // Select pulse far shorter than the filter span
  task automatic glitch();
    ss_b_out = 1'b0;
    #20;
    ss_b_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the serial port configuration and status block
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [11:0] CFG = spi_cfg_pkg::OFF_CFG_STATUS;
  localparam logic [11:0] DAT = spi_cfg_pkg::OFF_DATA;
  localparam logic [11:0] INT = spi_cfg_pkg::OFF_INT_STATUS;
  localparam logic [11:0] MSK = spi_cfg_pkg::OFF_INT_MASK;
  logic clk_sys_in, rst_b_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out, sck_in, mosi_in, ss_b_in, miso_out, miso_oe_b_out, irq_out;
  int n_errors = 0;
  int num_checks = 0;
  spi_config_status #(.FILTER_CYCLES(4)) dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .sck_in(sck_in), .mosi_in(mosi_in), .ss_b_in(ss_b_in), .miso_out(miso_out),
    .miso_oe_b_out(miso_oe_b_out), .irq_out(irq_out));
  spi_master_model master (.sck_out(sck_in), .mosi_out(mosi_in), .ss_b_out(ss_b_in), .miso_in(miso_out));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= addr;
    pwdata_in <= wd;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    check(8'(pready_out), 8'h01, "pready");
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, addr, wd, d, e);
    check(8'(e), 8'h00, "write error");
  endtask
  task automatic rd(input logic [11:0] addr, output logic [31:0] d);
    logic e;
    apb(1'b0, addr, 32'h0, d, e);
    check(8'(e), 8'h00, "read error");
  endtask
  task automatic off();
    @(posedge clk_sys_in);
    #3;
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic e;
    rd(CFG, d);
    check(d[7:0], spi_cfg_pkg::CFG_STATUS_RST, "cfg reset");
    rd(MSK, d);
    check(d[7:0], 8'(spi_cfg_pkg::IRQ_MASK_RST), "mask reset");
    apb(1'b0, 12'h010, 32'h0, d, e);
    check(8'(e), 8'h01, "unmapped error");
    check(d[7:0], 8'h00, "unmapped data");
    $display("test reset done");
  endtask
  task automatic t_select();
    logic [31:0] d;
    off();
    master.glitch();
    repeat (12) @(posedge clk_sys_in);
    rd(CFG, d);
    check(8'(d[spi_cfg_pkg::BIT_SLV_SEL]), 8'h00, "glitch selects");
    rd(INT, d);
    check(8'(d[spi_cfg_pkg::IRQ_SEL_EDGE]), 8'h00, "glitch event");
    off();
    master.select(1'b0);
    repeat (12) @(posedge clk_sys_in);
    rd(CFG, d);
    check(8'(d[spi_cfg_pkg::BIT_SLV_SEL]), 8'h01, "selected");
    check(8'(d[spi_cfg_pkg::BIT_RAW_SS]), 8'h00, "raw low");
    check(8'(miso_oe_b_out), 8'h00, "slave drives");
    rd(INT, d);
    check(8'(d[spi_cfg_pkg::IRQ_SEL_EDGE]), 8'h01, "select event");
    off();
    master.select(1'b1);
    repeat (12) @(posedge clk_sys_in);
    rd(CFG, d);
    check(8'(d[spi_cfg_pkg::BIT_SLV_SEL]), 8'h00, "deselected");
    check(8'(d[spi_cfg_pkg::BIT_RAW_SS]), 8'h01, "raw high");
    wr(INT, 32'h3);
    $display("test select done");
  endtask
  task automatic t_mode(input logic pol, input logic pha, input logic [7:0] tx, input logic [7:0] mo);
    logic [31:0] d;
    logic [7:0] got;
    wr(CFG, {26'h0, pha, pol, 4'h0});
    rd(CFG, d);
    check(8'(d[7:4]), {6'h0, pha, pol}, "mode readback");
    wr(MSK, 32'h1);
    wr(DAT, {24'h0, tx});
    off();
    master.xfer(pol, pha, mo, got);
    check(got, tx, "byte to master");
    rd(CFG, d);
    check(8'(d[spi_cfg_pkg::BIT_RX_EMPTY]), 8'h00, "rx held");
    check(8'(irq_out), 8'h01, "irq raised");
    rd(DAT, d);
    check(d[7:0], mo, "byte from master");
    rd(CFG, d);
    check(8'(d[spi_cfg_pkg::BIT_RX_EMPTY]), 8'h01, "rx read");
    rd(INT, d);
    check(8'(d[spi_cfg_pkg::IRQ_XFER_DONE]), 8'h01, "done sticky");
    wr(MSK, 32'h0);
    repeat (2) @(posedge clk_sys_in);
    check(8'(irq_out), 8'h00, "irq masked");
    wr(INT, 32'h3);
    rd(INT, d);
    check(d[7:0], 8'h00, "status cleared");
    $display("test mode %0d%0d done", pol, pha);
  endtask
  task automatic t_master();
    logic [31:0] d;
    logic [7:0] got;
    wr(CFG, 32'h0);
    off();
    master.xfer(1'b0, 1'b0, 8'h99, got);
    wr(CFG, 32'h40);
    rd(CFG, d);
    check(8'(d[spi_cfg_pkg::BIT_RX_EMPTY]), 8'h01, "rx empty as master");
    check(8'(d[spi_cfg_pkg::BIT_MASTER_EN]), 8'h01, "master readback");
    off();
    master.select(1'b0);
    repeat (12) @(posedge clk_sys_in);
    check(8'(miso_oe_b_out), 8'h01, "master keeps miso off");
    off();
    master.xfer(1'b0, 1'b0, 8'h66, got);
    wr(CFG, 32'h0);
    rd(CFG, d);
    check(8'(d[spi_cfg_pkg::BIT_RX_EMPTY]), 8'h00, "rx unread as slave");
    rd(DAT, d);
    check(d[7:0], 8'h99, "byte kept through master mode");
    wr(INT, 32'h3);
    $display("test master done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end
  initial begin
    rst_b_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    repeat (8) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_select();
    t_mode(1'b0, 1'b0, 8'ha5, 8'h3c);
    t_mode(1'b0, 1'b1, 8'h81, 8'h7e);
    t_mode(1'b1, 1'b0, 8'h5a, 8'hc3);
    t_mode(1'b1, 1'b1, 8'h01, 8'hfe);
    t_master();
    conclude();
  end
endmodule
`default_nettype wire

// ---- rtl/spi_config_status.sv ----
// Serial port configuration and status register block with slave engine
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Phase bit 0 samples on leading edge, 1 on trailing edge.
// - Polarity bit gives the idle level of the serial clock.
// - Slave-selected flag reads 1 while select is low, else 0.
// - Slave-selected flag follows the de-glitched select, not the raw pin.
// - Receive-empty flag goes to 1 once received data is read.
// - Receive-empty flag is 0 while unread received data is held in slave operation.
// - Receive-empty flag always reads 1 in master operation.
// - Transfer-complete flag set by hardware per byte, cleared only by software.
module spi_config_status #(
  parameter int FILTER_CYCLES = spi_cfg_pkg::SS_FILTER_CYCLES
) (
  input wire logic clk_sys_in, // System clock, 100 MHz
  input wire logic rst_b_in, // Sync reset, active low
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB direction
  input wire logic [11:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error, unmapped address
  input wire logic sck_in, // Serial clock from master
  input wire logic mosi_in, // Serial data in
  input wire logic ss_b_in, // Slave select, active low
  output logic miso_out, // Serial data out
  output logic miso_oe_b_out, // Data out enable, low drives
  output logic irq_out // Interrupt, active high level
);
  ss_filter_if ss_if ();

  ss_deglitch #(.FILTER_CYCLES(FILTER_CYCLES)) u_ss (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .ss_b_in(ss_b_in),
    .ss_if(ss_if)
  );

  // Pin synchronisers
  logic sck_m_r, sck_s_r, sck_d_r, mosi_m_r, mosi_s_r;
  // Bus side
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic master_en_r, master_en_nxt, phase_r, phase_nxt, pol_r, pol_nxt;
  logic [1:0] int_stat_r, int_stat_nxt, int_mask_r, int_mask_nxt;
  logic irq_r, irq_nxt;
  // Serial engine
  logic [7:0] tx_buf_r, tx_buf_nxt, tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt, rx_buf_r, rx_buf_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic tx_full_r, tx_full_nxt, rx_full_r, rx_full_nxt, loaded_r, loaded_nxt;
  logic miso_r, miso_nxt, oe_b_r, oe_b_nxt, sel_d_r, sel_d_nxt;

  logic access_done, wr_done, rd_done, addr_ok;
  logic active, selected, sck_lvl, sck_lvl_d, lead_ev, trail_ev, sample_ev, change_ev, byte_done;
  logic [7:0] cfg_rd;

  assign access_done = psel_in && penable_in && pready_r;
  assign wr_done = access_done && pwrite_in && !pslverr_r;
  assign rd_done = access_done && !pwrite_in && !pslverr_r;
  assign addr_ok = (paddr_in == spi_cfg_pkg::OFF_CFG_STATUS) || (paddr_in == spi_cfg_pkg::OFF_DATA) ||
                   (paddr_in == spi_cfg_pkg::OFF_INT_STATUS) || (paddr_in == spi_cfg_pkg::OFF_INT_MASK);

  assign selected = !ss_if.filtered_level;
  assign active = selected && !master_en_r;
  // Clock level relative to idle; leading edge leaves idle
  assign sck_lvl = sck_s_r ^ pol_r;
  assign sck_lvl_d = sck_d_r ^ pol_r;
  assign lead_ev = active && sck_lvl && !sck_lvl_d;
  assign trail_ev = active && !sck_lvl && sck_lvl_d;
  assign sample_ev = phase_r ? trail_ev : lead_ev;
  assign change_ev = (phase_r ? lead_ev : trail_ev) && (phase_r || bit_cnt_r != 3'h0);
  assign byte_done = sample_ev && bit_cnt_r == 3'h7;

  always_comb begin
    cfg_rd = '0;
    cfg_rd[spi_cfg_pkg::BIT_BUSY] = active && bit_cnt_r != 3'h0;
    cfg_rd[spi_cfg_pkg::BIT_MASTER_EN] = master_en_r;
    cfg_rd[spi_cfg_pkg::BIT_PHASE] = phase_r;
    cfg_rd[spi_cfg_pkg::BIT_POLARITY] = pol_r;
    cfg_rd[spi_cfg_pkg::BIT_SLV_SEL] = selected;
    cfg_rd[spi_cfg_pkg::BIT_RAW_SS] = ss_if.raw_level;
    cfg_rd[spi_cfg_pkg::BIT_SR_EMPTY] = !tx_full_r && !(active && bit_cnt_r != 3'h0);
    cfg_rd[spi_cfg_pkg::BIT_RX_EMPTY] = master_en_r || !rx_full_r;
  end

  // Bus and register next values
  always_comb begin
    pready_nxt = psel_in && penable_in && !pready_r;
    pslverr_nxt = pready_nxt && !addr_ok;
    prdata_nxt = '0;
    if (pready_nxt && !pwrite_in) begin
      case (paddr_in)
        spi_cfg_pkg::OFF_CFG_STATUS: prdata_nxt = {24'h000000, cfg_rd};
        spi_cfg_pkg::OFF_DATA: prdata_nxt = {24'h000000, rx_buf_r};
        spi_cfg_pkg::OFF_INT_STATUS: prdata_nxt = {30'h0, int_stat_r};
        spi_cfg_pkg::OFF_INT_MASK: prdata_nxt = {30'h0, int_mask_r};
        default: prdata_nxt = '0;
      endcase
    end
    master_en_nxt = master_en_r;
    phase_nxt = phase_r;
    pol_nxt = pol_r;
    int_mask_nxt = int_mask_r;
    int_stat_nxt = int_stat_r;
    if (wr_done && paddr_in == spi_cfg_pkg::OFF_CFG_STATUS) begin
      master_en_nxt = pwdata_in[spi_cfg_pkg::BIT_MASTER_EN];
      phase_nxt = pwdata_in[spi_cfg_pkg::BIT_PHASE];
      pol_nxt = pwdata_in[spi_cfg_pkg::BIT_POLARITY];
    end
    if (wr_done && paddr_in == spi_cfg_pkg::OFF_INT_MASK) begin
      int_mask_nxt = pwdata_in[1:0];
    end
    if (wr_done && paddr_in == spi_cfg_pkg::OFF_INT_STATUS) begin
      int_stat_nxt = int_stat_r & ~pwdata_in[1:0];
    end
    // Set wins over a same-cycle clear
    if (byte_done) begin
      int_stat_nxt[spi_cfg_pkg::IRQ_XFER_DONE] = 1'b1;
    end
    if (selected && !sel_d_r) begin
      int_stat_nxt[spi_cfg_pkg::IRQ_SEL_EDGE] = 1'b1;
    end
    irq_nxt = |(int_stat_nxt & int_mask_nxt);
  end

  // Serial engine next values
  always_comb begin
    tx_buf_nxt = tx_buf_r;
    tx_full_nxt = tx_full_r;
    tx_sh_nxt = tx_sh_r;
    rx_sh_nxt = rx_sh_r;
    rx_buf_nxt = rx_buf_r;
    rx_full_nxt = rx_full_r;
    bit_cnt_nxt = bit_cnt_r;
    loaded_nxt = loaded_r;
    miso_nxt = miso_r;
    oe_b_nxt = !active;
    sel_d_nxt = selected;
    if (wr_done && paddr_in == spi_cfg_pkg::OFF_DATA) begin
      tx_buf_nxt = pwdata_in[7:0];
      tx_full_nxt = 1'b1;
    end
    if (rd_done && paddr_in == spi_cfg_pkg::OFF_DATA) begin
      rx_full_nxt = 1'b0;
    end
    if (!active) begin
      bit_cnt_nxt = '0;
      loaded_nxt = 1'b0;
    end else if (!loaded_r && bit_cnt_r == 3'h0) begin
      // New byte; first bit goes out at once when sampling on the leading edge
      loaded_nxt = 1'b1;
      tx_sh_nxt = tx_full_nxt ? tx_buf_nxt : spi_cfg_pkg::TX_IDLE_BYTE;
      tx_full_nxt = 1'b0;
      if (!phase_r) begin
        miso_nxt = tx_sh_nxt[7];
        tx_sh_nxt = {tx_sh_nxt[6:0], 1'b0};
      end
    end else begin
      if (change_ev) begin
        miso_nxt = tx_sh_r[7];
        tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
      end
      if (sample_ev) begin
        rx_sh_nxt = {rx_sh_r[6:0], mosi_s_r};
        bit_cnt_nxt = bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7) begin
          rx_buf_nxt = {rx_sh_r[6:0], mosi_s_r};
          rx_full_nxt = 1'b1;
          loaded_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      mosi_m_r <= 1'b0;
      mosi_s_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      master_en_r <= spi_cfg_pkg::CFG_STATUS_RST[spi_cfg_pkg::BIT_MASTER_EN];
      phase_r <= spi_cfg_pkg::CFG_STATUS_RST[spi_cfg_pkg::BIT_PHASE];
      pol_r <= spi_cfg_pkg::CFG_STATUS_RST[spi_cfg_pkg::BIT_POLARITY];
      int_stat_r <= '0;
      int_mask_r <= spi_cfg_pkg::IRQ_MASK_RST;
      irq_r <= 1'b0;
      tx_buf_r <= '0;
      tx_full_r <= 1'b0;
      tx_sh_r <= '0;
      rx_sh_r <= '0;
      rx_buf_r <= '0;
      rx_full_r <= 1'b0;
      bit_cnt_r <= '0;
      loaded_r <= 1'b0;
      miso_r <= 1'b0;
      oe_b_r <= 1'b1;
      sel_d_r <= 1'b0;
    end else begin
      sck_m_r <= sck_in;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      mosi_m_r <= mosi_in;
      mosi_s_r <= mosi_m_r;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      master_en_r <= master_en_nxt;
      phase_r <= phase_nxt;
      pol_r <= pol_nxt;
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
      irq_r <= irq_nxt;
      tx_buf_r <= tx_buf_nxt;
      tx_full_r <= tx_full_nxt;
      tx_sh_r <= tx_sh_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_buf_r <= rx_buf_nxt;
      rx_full_r <= rx_full_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      loaded_r <= loaded_nxt;
      miso_r <= miso_nxt;
      oe_b_r <= oe_b_nxt;
      sel_d_r <= sel_d_nxt;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign miso_out = miso_r;
  assign miso_oe_b_out = oe_b_r;
  assign irq_out = irq_r;

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence rd_cfg_s;
    psel_in && penable_in && pready_nxt && !pwrite_in && paddr_in == spi_cfg_pkg::OFF_CFG_STATUS;
  endsequence
  sequence rd_data_s;
    rd_done && paddr_in == spi_cfg_pkg::OFF_DATA && !byte_done;
  endsequence

  phase_edge_a: assert property (sample_ev |-> (phase_r ? (sck_lvl_d && !sck_lvl) : (sck_lvl && !sck_lvl_d)))
    else $error("sample taken on wrong clock edge");
  idle_level_a: assert property (lead_ev |-> (sck_d_r == pol_r) && (sck_s_r != pol_r))
    else $error("leading edge did not leave idle level");
  sel_flag_a: assert property (rd_cfg_s |=> prdata_out[spi_cfg_pkg::BIT_SLV_SEL] == !$past(ss_if.filtered_level))
    else $error("slave selected flag wrong");
  deglitch_hold_a: assert property ($changed(ss_if.filtered_level) |->
    $past(ss_if.raw_level) == ss_if.filtered_level && $past(ss_if.raw_level, 2) == ss_if.filtered_level)
    else $error("filtered select followed a glitch");
  rx_read_a: assert property (rd_data_s ##1 (!master_en_r && !byte_done) |-> cfg_rd[spi_cfg_pkg::BIT_RX_EMPTY])
    else $error("receive empty not set after read");
  rx_fill_a: assert property (byte_done ##1 !master_en_r |-> !cfg_rd[spi_cfg_pkg::BIT_RX_EMPTY])
    else $error("receive empty not cleared by new byte");
  master_empty_a: assert property (rd_cfg_s ##0 master_en_r |=> prdata_out[spi_cfg_pkg::BIT_RX_EMPTY])
    else $error("receive empty not 1 in master mode");
  xfer_flag_a: assert property (byte_done |=> int_stat_r[spi_cfg_pkg::IRQ_XFER_DONE])
    else $error("transfer complete flag not set");
  xfer_sticky_a: assert property (int_stat_r[spi_cfg_pkg::IRQ_XFER_DONE] && !(wr_done &&
    paddr_in == spi_cfg_pkg::OFF_INT_STATUS && pwdata_in[0]) |=> int_stat_r[spi_cfg_pkg::IRQ_XFER_DONE])
    else $error("transfer complete flag cleared by hardware");
  raw_ss_a: assert property (rd_cfg_s |=> prdata_out[spi_cfg_pkg::BIT_RAW_SS] == $past(ss_if.raw_level))
    else $error("raw select bit wrong");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready held over two cycles");
endmodule
`default_nettype wire

// ---- rtl/ss_deglitch.sv ----
// Synchroniser and glitch filter for the slave select pin
`timescale 1ns/1ns
`default_nettype none
module ss_deglitch #(
  parameter int FILTER_CYCLES = spi_cfg_pkg::SS_FILTER_CYCLES
) (
  input wire logic clk_sys_in, // System clock
  input wire logic rst_b_in, // Sync reset, active low
  input wire logic ss_b_in, // Slave select pin, active low
  ss_filter_if.source ss_if // Raw and filtered levels
);
  localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(FILTER_CYCLES - 1);

  logic sync1_r, sync2_r, filt_r;
  logic sync1_nxt, sync2_nxt, filt_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;

  always_comb begin
    sync1_nxt = ss_b_in;
    sync2_nxt = sync1_r;
    filt_nxt = filt_r;
    cnt_nxt = '0;
    // Level must hold for the whole filter window before it is taken
    if (sync2_r != filt_r) begin
      if (cnt_r == CNT_MAX) begin
        filt_nxt = sync2_r;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      filt_r <= 1'b1;
      cnt_r <= '0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      filt_r <= filt_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign ss_if.raw_level = sync2_r;
  assign ss_if.filtered_level = filt_r;
endmodule
`default_nettype wire
